// file: hw/ovr_cfg.svh
// constants for the output over-voltage fault response sequencer
//
// What this block does
// - response 01 keeps output on for delay
// - after delay, fault still present: apply retries
// - response 10 disables output at once, retries
// - response 11 holds output off until cleared with the fault gone
// - bit clear or clear-faults command clears fault
// - off-then-on command clears fault
// - reset input clears the latched fault
// - retry count comes from bits five to three
// - retry count 000 makes no restart
// - retry count 111 retries without limit
// - retry count 001 makes one restart
// - restart starts spaced by programmed delay
// - response 00 keeps output on, fault flag still set
// - counts 010 to 110 give two to six
// - endless retry stops on off, bias, fault
// - delay field means two-power time units
`ifndef OVR_CFG_SVH
`define OVR_CFG_SVH

// ----------------------------------------------------------------
// command code and reset value of the response byte
// ----------------------------------------------------------------
`define OVR_CMD_CODE 8'h41
`define OVR_CFG_RESET 8'h80

// ----------------------------------------------------------------
// field positions inside the response byte
// ----------------------------------------------------------------
`define OVR_RESP_MSB 7
`define OVR_RESP_LSB 6
`define OVR_RETRY_MSB 5
`define OVR_RETRY_LSB 3
`define OVR_DELAY_MSB 2
`define OVR_DELAY_LSB 0

// ----------------------------------------------------------------
// retry field codes and delay counter width
// ----------------------------------------------------------------
`define OVR_RETRY_NONE 3'h0
`define OVR_RETRY_ENDLESS 3'h7
`define OVR_DELAY_CNT_W 8

`endif

// file: hw/ovr_pkg.sv
// types shared by the over-voltage fault response sequencer
`default_nettype none
package ovr_pkg;

    // response action in the top two bits
    typedef enum logic [1:0]
    {
        OVR_RESP_IGNORE = 2'h0,
        OVR_RESP_DELAY_RETRY = 2'h1,
        OVR_RESP_DISABLE_RETRY = 2'h2,
        OVR_RESP_HOLD = 2'h3
    } ovr_resp_t;

    // layout of the response byte, msb first
    typedef struct packed
    {
        ovr_resp_t resp;
        logic [2:0] retries;
        logic [2:0] delay;
    } ovr_cfg_t;

    // on/off commands from pin and operation command
    typedef struct packed
    {
        logic ctrl_pin_on;
        logic operation_on;
    } ovr_cmd_t;

    // host clearing requests, one-cycle pulses
    typedef struct packed
    {
        logic clear_bit;
        logic clear_faults;
    } ovr_clr_t;

    // sequencer states
    typedef enum logic [1:0]
    {
        OVR_ST_RUN = 2'b00,
        OVR_ST_DELAY = 2'b01,
        OVR_ST_RETRY_WAIT = 2'b10,
        OVR_ST_LATCH = 2'b11
    } ovr_state_t;

endpackage
`default_nettype wire

// file: hw/ovr_delay_timer.sv
// delay timer counting two-power multiples of an external time unit
`include "ovr_cfg.svh"
`default_nettype none
module ovr_delay_timer
    import ovr_pkg::*;
#(
    parameter int CNT_W = `OVR_DELAY_CNT_W
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic start,
    input wire logic [2:0] exp_sel,
    input wire logic unit_tick,
    output logic done,
    output logic busy
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // last count value for a delay code: 2**code units, minus one
    function automatic logic [CNT_W-1:0] last_count(input logic [2:0] code);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        last_count = (one << code) - one;
    endfunction

    logic [CNT_W-1:0] cnt; // units elapsed so far
    logic [CNT_W-1:0] last; // terminal value latched at start

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // latch the code at start so a config write mid-delay cannot stretch it
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= '0;
            last <= '0;
            busy <= 1'b0;
        end
        else if (start)
        begin
            cnt <= '0;
            last <= last_count(exp_sel);
            busy <= 1'b1;
        end
        else if (busy && unit_tick)
        begin
            // stop on the final unit
            if (cnt == last)
                busy <= 1'b0;
            else
                cnt <= cnt + 1'b1;
        end
    end

    // done pulse one cycle after the final unit tick
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            done <= 1'b0;
        else
            done <= busy && unit_tick && (cnt == last) && !start;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_timer_length: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        done |-> $past(cnt) == $past(last) && $past(unit_tick))
    else $error("delay ended before its unit count");

endmodule
`default_nettype wire

// file: hw/ovr_fault_seq.sv
// output over-voltage fault response sequencer
`include "ovr_cfg.svh"
`default_nettype none
module ovr_fault_seq
    import ovr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cfg_rd_data,
    input wire logic ov_fault,
    input wire logic unit_tick,
    input wire ovr_cmd_t on_cmd,
    input wire ovr_clr_t clr_req,
    input wire logic bias_ok,
    input wire logic other_fault_stop,
    output logic output_enable,
    output logic ov_fault_flag,
    output logic [2:0] attempts_left,
    output ovr_state_t seq_state
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ovr_cfg_t cfg; // output_overvoltage_response_cfg
    ovr_state_t next_state; // combinational next state
    logic cmd_on; // pin and operation both ask for on
    logic cmd_on_q; // previous cmd_on, for the on edge
    logic on_edge; // output commanded on afresh
    logic clr_evt; // any accepted clearing event
    logic tmr_start; // load the delay timer
    logic tmr_done; // delay elapsed
    logic tmr_busy; // delay running
    logic endless; // retry field asks for no limit
    logic stop_retry; // bias lost or other shutdown
    logic cfg_wr; // host write aimed at the response byte

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // after a shutdown: wait to retry while budget remains, else latch
    function automatic ovr_state_t after_shutdown(input logic [2:0] left);
        if (left == `OVR_RETRY_NONE)
            after_shutdown = OVR_ST_LATCH;
        else
            after_shutdown = OVR_ST_RETRY_WAIT;
    endfunction

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    // both control sources must agree; either dropping counts as off
    assign cmd_on = on_cmd.ctrl_pin_on && on_cmd.operation_on;
    assign on_edge = cmd_on && !cmd_on_q;
    assign clr_evt = clr_req.clear_bit || clr_req.clear_faults || on_edge;
    assign endless = (cfg.retries == `OVR_RETRY_ENDLESS);
    assign stop_retry = !bias_ok || other_fault_stop;
    // only the response byte's own code may write it
    assign cfg_wr = cmd_wr && (cmd_code == `OVR_CMD_CODE);

    // remember last command level
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cmd_on_q <= 1'b0;
        else
            cmd_on_q <= cmd_on;
    end

    // ----------------------------------------------------------------
    // response byte
    // ----------------------------------------------------------------
    // written by the host under its own command code
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cfg <= ovr_cfg_t'(`OVR_CFG_RESET);
        else if (cfg_wr)
            cfg <= ovr_cfg_t'(cmd_wdata);
    end

    // read back the stored byte
    assign cfg_rd_data = cfg;

    // ----------------------------------------------------------------
    // fault status flag
    // ----------------------------------------------------------------
    // a fault in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            ov_fault_flag <= 1'b0;
        else if (ov_fault)
            ov_fault_flag <= 1'b1;
        else if (clr_evt)
            ov_fault_flag <= 1'b0;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // clearing first, then other shutdown, then bias loss or command off
    always_comb
    begin
        next_state = seq_state;
        if (clr_evt)
        begin
            // hold mode stays off while the fault is still there
            if (seq_state == OVR_ST_LATCH && cfg.resp == OVR_RESP_HOLD && ov_fault)
                next_state = OVR_ST_LATCH;
            else
                next_state = OVR_ST_RUN;
        end
        else if (other_fault_stop)
            next_state = OVR_ST_LATCH;
        else if (!bias_ok || !cmd_on)
        begin
            // off or unpowered: drop any pending retry
            if (seq_state != OVR_ST_LATCH)
                next_state = OVR_ST_RUN;
        end
        else
        begin
            case (seq_state)
                OVR_ST_RUN:
                begin
                    if (ov_fault)
                    begin
                        case (cfg.resp)
                            OVR_RESP_IGNORE: next_state = OVR_ST_RUN;
                            OVR_RESP_DELAY_RETRY: next_state = OVR_ST_DELAY;
                            OVR_RESP_DISABLE_RETRY: next_state = after_shutdown(attempts_left);
                            default: next_state = OVR_ST_LATCH;
                        endcase
                    end
                end
                OVR_ST_DELAY:
                begin
                    // output keeps running; act only if fault outlives delay
                    if (tmr_done)
                    begin
                        if (ov_fault)
                            next_state = after_shutdown(attempts_left);
                        else
                            next_state = OVR_ST_RUN;
                    end
                end
                OVR_ST_RETRY_WAIT:
                begin
                    // output off; restart once the spacing has elapsed
                    if (tmr_done)
                        next_state = OVR_ST_RUN;
                end
                OVR_ST_LATCH:
                    next_state = OVR_ST_LATCH;
                default:
                    next_state = OVR_ST_LATCH;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            seq_state <= OVR_ST_RUN;
        else
            seq_state <= next_state;
    end

    // ----------------------------------------------------------------
    // retry budget
    // ----------------------------------------------------------------
    // refilled on every clear or fresh on; spent when a restart begins
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            attempts_left <= 3'(`OVR_CFG_RESET >> `OVR_RETRY_LSB);
        else if (clr_evt || !cmd_on)
            attempts_left <= cfg.retries;
        // a new byte takes effect at once, not only after the next clear
        else if (cfg_wr)
            attempts_left <= cmd_wdata[`OVR_RETRY_MSB:`OVR_RETRY_LSB];
        else if (seq_state == OVR_ST_RETRY_WAIT && next_state == OVR_ST_RUN && !endless)
            attempts_left <= attempts_left - 3'h1;
    end

    // ----------------------------------------------------------------
    // delay timer
    // ----------------------------------------------------------------
    // one timer serves both the operate delay and the restart spacing
    assign tmr_start = (next_state != seq_state) &&
        (next_state == OVR_ST_DELAY || next_state == OVR_ST_RETRY_WAIT);

    ovr_delay_timer #(
        .CNT_W(`OVR_DELAY_CNT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(tmr_start),
        .exp_sel(cfg.delay),
        .unit_tick(unit_tick),
        .done(tmr_done),
        .busy(tmr_busy)
    );

    // ----------------------------------------------------------------
    // output enable
    // ----------------------------------------------------------------
    // registered; on only in run or delay with power and command
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            output_enable <= 1'b0;
        else
            output_enable <= cmd_on && !stop_retry &&
                (next_state == OVR_ST_RUN || next_state == OVR_ST_DELAY);
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_ignore_keeps_on: assert property (
        seq_state == OVR_ST_RUN && ov_fault && cfg.resp == OVR_RESP_IGNORE &&
        cmd_on && bias_ok && !other_fault_stop && !clr_evt |=> output_enable)
    else $error("ignored fault turned output off");

    a_delay_keeps_on: assert property (
        seq_state == OVR_ST_DELAY && !tmr_done && cmd_on && bias_ok &&
        !other_fault_stop && !clr_evt
        |=> output_enable && seq_state == OVR_ST_DELAY)
    else $error("output dropped during operate delay");

    a_disable_now: assert property (
        seq_state == OVR_ST_RUN && ov_fault && cfg.resp == OVR_RESP_DISABLE_RETRY &&
        !clr_evt |=> !output_enable)
    else $error("disable response left output on");

    a_delay_then_act: assert property (
        seq_state == OVR_ST_DELAY && tmr_done && ov_fault && cmd_on && bias_ok &&
        !other_fault_stop && !clr_evt |=> !output_enable &&
        seq_state == after_shutdown($past(attempts_left)))
    else $error("fault outliving delay not acted on");

    a_hold_latched: assert property (
        seq_state == OVR_ST_LATCH && !clr_evt |=> seq_state == OVR_ST_LATCH && !output_enable)
    else $error("latched output came back without clear");

    a_clear_exits: assert property (
        seq_state == OVR_ST_LATCH && clr_req.clear_faults && !ov_fault
        |=> seq_state == OVR_ST_RUN)
    else $error("clear-faults did not release latch");

    a_on_edge_clears: assert property (
        !cmd_on ##1 cmd_on && !ov_fault |=> !ov_fault_flag)
    else $error("off-then-on did not clear flag");

    a_flag_sticky: assert property (
        ov_fault_flag && !clr_evt |=> ov_fault_flag)
    else $error("fault flag dropped without clear");

    a_no_budget_latch: assert property (
        seq_state == OVR_ST_RUN && ov_fault && cfg.resp == OVR_RESP_DISABLE_RETRY &&
        attempts_left == 3'h0 && cmd_on && bias_ok && !other_fault_stop && !clr_evt
        |=> seq_state == OVR_ST_LATCH)
    else $error("empty budget still retried");

    a_endless_keeps: assert property (
        seq_state == OVR_ST_RETRY_WAIT && tmr_done && endless && cmd_on && bias_ok &&
        !other_fault_stop && !clr_evt |=> seq_state == OVR_ST_RUN &&
        attempts_left == $past(attempts_left))
    else $error("endless retry spent budget");

    a_budget_refill: assert property (
        clr_evt |=> attempts_left == $past(cfg.retries))
    else $error("retry budget not refilled");

    a_wait_is_off: assert property (
        seq_state == OVR_ST_RETRY_WAIT |-> !output_enable && tmr_busy || tmr_done)
    else $error("restart spacing not timed");

    // retrying stops on power loss or a foreign shutdown
    a_bias_loss_idle: assert property (
        !bias_ok && !other_fault_stop && !clr_evt && seq_state != OVR_ST_LATCH
        |=> seq_state == OVR_ST_RUN && !output_enable)
    else $error("bias loss did not stop retrying");

    a_other_stop_latch: assert property (
        other_fault_stop && !clr_evt |=> seq_state == OVR_ST_LATCH && !output_enable)
    else $error("other shutdown did not latch off");

    a_write_budget: assert property (
        cfg_wr && cmd_on && !clr_evt |=> attempts_left == cfg.retries)
    else $error("retry budget ignored new byte");

endmodule
`default_nettype wire

// file: testbench/ovr_host_model.sv
// host stand-in driving the response byte, clear requests and on/off commands
`default_nettype none
module ovr_host_model
    import ovr_pkg::*;
(
    input wire logic clk_sys,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    output ovr_cmd_t on_cmd,
    output ovr_clr_t clr_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // idle levels at time zero
    // ----------------------------------------------------------------
    initial
    begin
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
        on_cmd = 2'b11;
        clr_req = 2'b00;
    end

    // ----------------------------------------------------------------
    // host transactions, entered just after a rising edge
    // ----------------------------------------------------------------
    // one-cycle strobe; code and byte held through the taking edge
    task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
        cmd_code = code;
        cmd_wdata = data;
        cmd_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        cmd_wr = 1'b0;
        // lines left inverted so a stale byte can never be mistaken for data
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask

    // single-cycle clear pulse, bit clear or clear-faults command
    task automatic clear(input logic use_bit);
        clr_req = use_bit ? 2'b10 : 2'b01;
        @(posedge clk_sys);
        #1;
        clr_req = 2'b00;
    endtask

    // off for three cycles, then on again, via pin or operation command
    task automatic cycle_on(input logic use_pin);
        on_cmd = use_pin ? 2'b01 : 2'b10;
        repeat (3) @(posedge clk_sys);
        #1;
        on_cmd = 2'b11;
    endtask

    // plain level change of both commands
    task automatic set_on(input logic [1:0] v);
        on_cmd = v;
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the over-voltage fault response sequencer
`default_nettype none
module tb_top
    import ovr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ov_fault = 1'b0;
    logic unit_tick = 1'b0;
    logic bias_ok = 1'b1;
    logic other_fault_stop = 1'b0;
    logic [1:0] tick_cnt = 2'h0; // unit tick every fourth cycle
    wire logic cmd_wr;
    wire logic [7:0] cmd_code;
    wire logic [7:0] cmd_wdata;
    wire ovr_cmd_t on_cmd;
    wire ovr_clr_t clr_req;
    logic [7:0] cfg_rd_data;
    logic output_enable;
    logic ov_fault_flag;
    logic [2:0] attempts_left;
    ovr_state_t seq_state;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    // free-running time unit; gaps are judged with seven cycles of slack
    always @(posedge clk_sys)
    begin
        #1;
        tick_cnt = tick_cnt + 2'h1;
        unit_tick = (tick_cnt == 2'h0);
    end

    ovr_host_model host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .on_cmd(on_cmd), .clr_req(clr_req));

    ovr_fault_seq dut (.clk_sys(clk_sys), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cfg_rd_data(cfg_rd_data), .ov_fault(ov_fault),
        .unit_tick(unit_tick), .on_cmd(on_cmd), .clr_req(clr_req), .bias_ok(bias_ok),
        .other_fault_stop(other_fault_stop), .output_enable(output_enable),
        .ov_fault_flag(ov_fault_flag), .attempts_left(attempts_left), .seq_state(seq_state));

    // ----------------------------------------------------------------
    // compare, stepping and closing
    // ----------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard well above the longest sequence
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // reset values, refused code, accepted write
    task automatic t_register();
        chk_val("cfg reset", 8'h80, cfg_rd_data);
        chk_bit("enable after reset", 1'b1, output_enable);
        host.write_byte(8'h42, 8'h55);
        chk_val("cfg other code", 8'h80, cfg_rd_data);
        step(1);
        host.write_byte(8'h41, 8'h5a);
        chk_val("cfg written", 8'h5a, cfg_rd_data);
    endtask

    // disable-and-retry: restart count, spacing, latch, clearing, refill
    task automatic t_retry(input logic [2:0] rt, input logic [2:0] dl);
        int restarts;
        int gap;
        int lo;
        logic prev;
        host.write_byte(8'h41, {2'h2, rt, dl});
        ov_fault = 1'b1;
        restarts = 0;
        gap = 0;
        prev = 1'b1;
        lo = 4 * ((1 << dl) - 1) + 1;
        for (int i = 0; i < 4000 && seq_state !== OVR_ST_LATCH; i++)
        begin
            step(1);
            if (output_enable === 1'b0)
                gap++;
            if (output_enable === 1'b1 && prev === 1'b0)
            begin
                restarts++;
                chk_bit("gap low", 1'b1, gap >= lo);
                chk_bit("gap high", 1'b1, gap <= lo + 7);
                gap = 0;
            end
            prev = output_enable;
            if (rt == 3'h7 && restarts == 4)
                break;
        end
        if (rt == 3'h7)
        begin
            chk_val("endless budget", 8'h07, attempts_left);
            bias_ok = 1'b0;
            step(1);
            chk_val("bias loss state", OVR_ST_RUN, seq_state);
            chk_bit("bias loss off", 1'b0, output_enable);
            bias_ok = 1'b1;
            step(2);
            host.set_on(2'b10);
            step(2);
            chk_bit("endless off", 1'b0, output_enable);
            chk_val("endless off state", OVR_ST_RUN, seq_state);
            ov_fault = 1'b0;
            host.set_on(2'b11);
            step(2);
            host.clear(1'b0);
        end
        else
        begin
            chk_val("restarts", rt, restarts);
            chk_bit("latched off", 1'b0, output_enable);
            chk_bit("flag held", 1'b1, ov_fault_flag);
            ov_fault = 1'b0;
            step(3);
            chk_bit("still off", 1'b0, output_enable);
            if (rt[1] == 1'b0)
                host.clear(rt[0]);
            else
                host.cycle_on(rt[0]);
        end
        step(3);
        chk_bit("on after clear", 1'b1, output_enable);
        chk_bit("flag cleared", 1'b0, ov_fault_flag);
        chk_val("budget refill", rt, attempts_left);
    endtask

    // run-for-delay: short fault recovers, held fault shuts down on time
    task automatic t_delay();
        int on_time;
        host.write_byte(8'h41, 8'h42);
        ov_fault = 1'b1;
        step(3);
        chk_val("delay state", OVR_ST_DELAY, seq_state);
        ov_fault = 1'b0;
        step(30);
        chk_val("recovered", OVR_ST_RUN, seq_state);
        chk_bit("kept on", 1'b1, output_enable);
        ov_fault = 1'b1;
        on_time = 0;
        for (int i = 0; i < 100 && output_enable === 1'b1; i++)
        begin
            step(1);
            on_time++;
        end
        chk_bit("on time low", 1'b1, on_time >= 13);
        chk_bit("on time high", 1'b1, on_time <= 20);
        step(1);
        chk_val("no retry latch", OVR_ST_LATCH, seq_state);
        ov_fault = 1'b0;
        host.clear(1'b1);
        step(2);
    endtask

    // hold-off response and ignore response, other shutdown, reset clear
    task automatic t_hold_ignore();
        host.write_byte(8'h41, 8'hc0);
        ov_fault = 1'b1;
        step(2);
        chk_bit("hold off", 1'b0, output_enable);
        host.clear(1'b0);
        step(2);
        chk_val("hold ignores clear", OVR_ST_LATCH, seq_state);
        ov_fault = 1'b0;
        host.clear(1'b0);
        step(2);
        chk_bit("hold released", 1'b1, output_enable);
        host.write_byte(8'h41, 8'h00);
        ov_fault = 1'b1;
        step(10);
        chk_bit("ignore on", 1'b1, output_enable);
        chk_val("ignore state", OVR_ST_RUN, seq_state);
        ov_fault = 1'b0;
        step(2);
        chk_bit("ignore flag", 1'b1, ov_fault_flag);
        other_fault_stop = 1'b1;
        step(2);
        chk_val("other stop", OVR_ST_LATCH, seq_state);
        other_fault_stop = 1'b0;
        nrst = 1'b0;
        step(2);
        chk_bit("reset flag", 1'b0, ov_fault_flag);
        chk_val("reset cfg", 8'h80, cfg_rd_data);
        nrst = 1'b1;
        step(2);
        chk_bit("reset on", 1'b1, output_enable);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        step(20);
        nrst = 1'b1;
        step(2);
        t_register();
        for (int r = 0; r < 8; r++)
            t_retry(r[2:0], 3'h1);
        for (int d = 0; d < 4; d++)
            t_retry(3'h1, d[2:0]);
        t_delay();
        t_hold_ignore();
        test_done();
    end
endmodule
`default_nettype wire
